// *** dv/rci_chk_sva.sv ***
// port checker for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module rci_chk_sva (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic power_on_evt,
  input wire logic brownout_evt,
  input wire logic master_clear_pin_n,
  input wire logic reset_instr_evt,
  input wire logic wdog_timeout_evt,
  input wire logic stack_overflow_evt,
  input wire logic stack_underflow_evt,
  input wire logic irq_wake_evt,
  input wire logic irq_wake_low,
  input wire logic [1:0] pm_mode,
  input wire logic [20:0] cur_pc,
  input wire logic stack_overflow_reset_enable,
  input wire logic gpio_bank_a_pins_free,
  input wire logic core_reset,
  input wire logic pc_load,
  input wire logic [20:0] pc_target,
  input wire logic [7:0] gpio_bank_a_lat,
  input wire logic [7:0] gpio_bank_a_dir
);
  logic [3:0] pin_q;
  logic lone;
  // pin history, so a pending pin reset spoils no single-event check
  always_ff @(posedge sys_clk)
  begin
    pin_q <= {pin_q[2:0], master_clear_pin_n};
  end
  // exactly one event pulse and a quiet pin
  assign lone = (&pin_q) && (power_on_evt + brownout_evt + reset_instr_evt
    + wdog_timeout_evt + stack_overflow_evt + stack_underflow_evt
    + irq_wake_evt == 3'h1);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_por;
    power_on_evt |=> core_reset && pc_load && pc_target == 21'h000000;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on not answered");
  property p_rst_vec;
    core_reset |-> pc_load && pc_target == 21'h000000;
  endproperty
  a_rst_vec: assert property (p_rst_vec)
    else $error("reset without reset vector");
  property p_pin;
    $fell(master_clear_pin_n) |-> ##[1:6] core_reset;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin reset not taken");
  property p_wd_run;
    lone && wdog_timeout_evt && !pm_mode[1] |=> core_reset;
  endproperty
  a_wd_run: assert property (p_wd_run)
    else $error("watchdog reset missing");
  property p_unf;
    lone && stack_underflow_evt && stack_overflow_reset_enable |=> core_reset;
  endproperty
  a_unf: assert property (p_unf)
    else $error("underflow reset missing");
  property p_unf_err;
    lone && stack_underflow_evt && !stack_overflow_reset_enable |=>
      !core_reset && pc_load && pc_target == 21'h000000;
  endproperty
  a_unf_err: assert property (p_unf_err)
    else $error("underflow error handled wrongly");
  property p_wd_wake;
    lone && wdog_timeout_evt && pm_mode[1] |=> !core_reset && pc_load
      && pc_target == $past(cur_pc) + 21'h000002;
  endproperty
  a_wd_wake: assert property (p_wd_wake)
    else $error("watchdog wake target wrong");
  property p_irq_full;
    lone && irq_wake_evt && pm_mode == 2'b00 |=> !pc_load [*2];
  endproperty
  a_irq_full: assert property (p_irq_full)
    else $error("wake taken in full power");
  property p_irq_vec;
    lone && irq_wake_evt && pm_mode != 2'b00 |=> pc_load && !core_reset
      && (pc_target == $past(cur_pc) + 21'h000002 || pc_target ==
      ($past(irq_wake_low) ? 21'h000018 : 21'h000008));
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("interrupt wake target wrong");
  property p_gpio_bank_a;
    !gpio_bank_a_pins_free [*2] |-> gpio_bank_a_lat[7:6] == 2'h0
      && gpio_bank_a_dir[7:6] == 2'h0;
  endproperty
  a_gpio_bank_a: assert property (p_gpio_bank_a)
    else $error("port A upper bits not hidden");
  c_wake: cover property (lone && irq_wake_evt && pm_mode != 2'b00);
  c_pin: cover property ($fell(master_clear_pin_n));
  c_unf: cover property (lone && stack_underflow_evt);
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, core_reset, pc_load, brownout_active;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] ev = 7'h00;
  logic master_clear_pin_n = 1'b1, irq_wake_low = 1'b0;
  logic [7:0] irq_wake_flags = 8'h00, gpio_bank_a_pin = 8'h00;
  logic [1:0] pm_mode = 2'b00, brownout_enable_config = 2'b01;
  logic [20:0] cur_pc = 21'h000000, pc_target;
  logic stack_overflow_reset_enable = 1'b1, gpio_bank_a_pins_free = 1'b1;
  logic [7:0] gpio_bank_a_lat, gpio_bank_a_dir;
  logic [31:0] rng_q = 32'h00003674;
  logic [33:0] rq[$], bq[$];
  logic [20:0] pq[$];
  int fail_count = 0;
  int comparisons = 0;
  // registers with their power-on and reset-class values
  localparam logic [4:0] TIX [8] = '{5'h02, 5'h03, 5'h0D, 5'h0E, 5'h0F,
    5'h12, 5'h14, 5'h15};
  localparam logic [7:0] TPOR [8] = '{8'h00, 8'h00, 8'hFF, 8'hC0, 8'h00,
    8'h05, 8'hFF, 8'h00};
  localparam logic [7:0] TRST [8] = '{8'h00, 8'h00, 8'hFF, 8'hC0, 8'h00,
    8'h05, 8'h00, 8'h7F};
  rci_reset_cause dut (
    .sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_on_evt(ev[0]), .brownout_evt(ev[1]), .reset_instr_evt(ev[2]),
    .wdog_timeout_evt(ev[3]), .stack_overflow_evt(ev[4]),
    .stack_underflow_evt(ev[5]), .irq_wake_evt(ev[6]), .master_clear_pin_n,
    .irq_wake_low, .irq_wake_flags, .pm_mode, .cur_pc,
    .brownout_enable_config, .stack_overflow_reset_enable, .gpio_bank_a_pins_free,
    .gpio_bank_a_pin, .core_reset, .pc_load, .pc_target, .brownout_active,
    .gpio_bank_a_lat, .gpio_bank_a_dir
  );
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // register write, address and data offered together
  task automatic axw(input logic [4:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    bq.push_back({(ix >= 5'h19) ? rci_pkg::RESP_SLVERR : rci_pkg::RESP_OKAY,
      32'h00000000});
    @(posedge sys_clk);
    s_axi_awaddr <= {1'b0, ix, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    fail_count += int'(n >= 50);
  endtask
  // register read; expected word noted for the monitor
  task automatic axr(input logic [4:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    rq.push_back({(ix >= 5'h19) ? rci_pkg::RESP_SLVERR : rci_pkg::RESP_OKAY,
      24'h000000, d});
    @(posedge sys_clk);
    s_axi_araddr <= {1'b0, ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    fail_count += int'(n >= 50);
  endtask
  // one event pulse; k picks the expected target, 4 means no load
  task automatic fire(input logic [6:0] v, input logic [1:0] md, input int k);
    logic [20:0] p;
    rng_q = xs(rng_q);
    p = {rng_q[20:1], 1'b0};
    case (k)
      0: pq.push_back(rci_pkg::VEC_RESET);
      1: pq.push_back(p + rci_pkg::PC_STEP);
      2: pq.push_back(rci_pkg::VEC_IRQ_HI);
      3: pq.push_back(rci_pkg::VEC_IRQ_LO);
      default: ;
    endcase
    @(posedge sys_clk);
    pm_mode <= md;
    cur_pc <= p;
    irq_wake_flags <= rng_q[28:21];
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 7'h00;
    repeat (3) @(posedge sys_clk);
  endtask
  // pin reset held low for six cycles
  task automatic pin_reset(input logic [1:0] md);
    pq.push_back(rci_pkg::VEC_RESET);
    @(posedge sys_clk);
    pm_mode <= md;
    @(posedge sys_clk);
    master_clear_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    master_clear_pin_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  // results taken off the queues as they appear
  always @(posedge sys_clk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check({s_axi_bresp, 32'h00000000}, bq.pop_front());
    if (pc_load === 1'b1)
      check({13'h0000, pc_target}, {13'h0000, pq.pop_front()});
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    axr(rci_pkg::IX_RSTAT, 8'h5C);
    foreach (TIX[i]) axr(TIX[i], TPOR[i]);
    axr(5'h19, 8'h00);
    axw(5'h19, 8'hFF);
    rng_q = xs(rng_q);
    axw(rci_pkg::IX_T2_PER, rng_q[7:0]);
    axr(rci_pkg::IX_T2_PER, rng_q[7:0] & 8'h7F);
    $display("test power-on values done");
    axw(rci_pkg::IX_RSTAT, 8'h53);
    axr(rci_pkg::IX_RSTAT, 8'h5F);
    fire(7'h04, 2'b00, 0);
    axr(rci_pkg::IX_RSTAT, 8'h4F);
    check(34'(brownout_active), 34'h1);
    fire(7'h02, 2'b00, 0);
    axr(rci_pkg::IX_RSTAT, 8'h5E);
    fire(7'h08, 2'b00, 0);
    axr(rci_pkg::IX_RSTAT, 8'h56);
    pin_reset(2'b01);
    axr(rci_pkg::IX_RSTAT, 8'h5E);
    fire(7'h08, 2'b01, 0);
    axr(rci_pkg::IX_RSTAT, 8'h56);
    pin_reset(2'b11);
    axr(rci_pkg::IX_RSTAT, 8'h5A);
    foreach (TIX[i])
    begin
      rng_q = xs(rng_q);
      axw(TIX[i], rng_q[7:0]);
    end
    axw(rci_pkg::IX_PA_LAT, 8'hA5);
    pin_reset(2'b00);
    axr(rci_pkg::IX_RSTAT, 8'h5A);
    foreach (TIX[i]) axr(TIX[i], TRST[i]);
    axr(rci_pkg::IX_PA_LAT, 8'hA5);
    $display("test reset causes done");
    axw(5'h14, 8'hA5);
    axw(rci_pkg::IX_T2_PER, 8'h11);
    fire(7'h08, 2'b11, 1);
    axr(rci_pkg::IX_RSTAT, 8'h52);
    axr(5'h14, 8'hA5);
    axr(rci_pkg::IX_T2_PER, 8'h7F);
    fire(7'h02, 2'b00, 0);
    fire(7'h40, 2'b10, 1);
    axr(rci_pkg::IX_RSTAT, 8'h5A);
    fire(7'h40, 2'b00, 4);
    axw(rci_pkg::IX_IRQCTL, 8'h80);
    fire(7'h40, 2'b10, 2);
    axr(rci_pkg::IX_IRQCTL, 8'h80 | (irq_wake_flags & 8'h07));
    axr(rci_pkg::IX_TOP_L, cur_pc[7:0]);
    axr(rci_pkg::IX_TOP_U, {3'h0, cur_pc[20:16]});
    axr(rci_pkg::IX_RSP, 8'h01);
    irq_wake_low <= 1'b1;
    fire(7'h40, 2'b11, 3);
    axr(rci_pkg::IX_RSP, 8'h02);
    $display("test wake-ups done");
    fire(7'h10, 2'b00, 0);
    axr(rci_pkg::IX_RSP, 8'h80);
    fire(7'h20, 2'b00, 0);
    axr(rci_pkg::IX_RSP, 8'hC0);
    axw(rci_pkg::IX_RSP, 8'h00);
    stack_overflow_reset_enable <= 1'b0;
    fire(7'h20, 2'b00, 0);
    axr(rci_pkg::IX_RSP, 8'h40);
    gpio_bank_a_pins_free <= 1'b0;
    axw(rci_pkg::IX_PA_LAT, 8'hFF);
    axr(rci_pkg::IX_PA_LAT, 8'h3F);
    check(34'(gpio_bank_a_dir), 34'h3F);
    rng_q = xs(rng_q);
    gpio_bank_a_pin <= rng_q[7:0];
    repeat (3) @(posedge sys_clk);
    axr(rci_pkg::IX_PA_PIN, rng_q[7:0] & 8'h3F);
    fire(7'h05, 2'b00, 0);
    axr(rci_pkg::IX_RSTAT, 8'h5C);
    brownout_enable_config <= 2'b11;
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    axw(rci_pkg::IX_RSTAT, 8'h50);
    axr(rci_pkg::IX_RSTAT, 8'h1C);
    $display("test stack, port and priority done");
    conclude();
  end
endmodule
bind rci_reset_cause rci_chk_sva u_sva (.sys_clk, .srst, .power_on_evt,
  .brownout_evt, .master_clear_pin_n, .reset_instr_evt, .wdog_timeout_evt,
  .stack_overflow_evt, .stack_underflow_evt, .irq_wake_evt, .irq_wake_low,
  .pm_mode, .cur_pc, .stack_overflow_reset_enable, .gpio_bank_a_pins_free,
  .core_reset, .pc_load, .pc_target, .gpio_bank_a_lat, .gpio_bank_a_dir);
`default_nettype wire

// *** src/rci_pkg.sv ***
// package: register map, reset tables and state layout of the reset-cause block
package rci_pkg;
  localparam int NREG = 25;
  localparam int AXI_AW = 8;
  localparam int PC_W = 21;
  localparam int PTR_W = 5;

  // register indices; byte address is index times four
  localparam logic [4:0] IX_RSTAT = 5'h00;
  localparam logic [4:0] IX_RSP = 5'h01;
  localparam logic [4:0] IX_TOP_U = 5'h02;
  localparam logic [4:0] IX_TOP_H = 5'h03;
  localparam logic [4:0] IX_TOP_L = 5'h04;
  localparam logic [4:0] IX_PC_LO = 5'h07;
  localparam logic [4:0] IX_IRQCTL = 5'h0C;
  localparam logic [4:0] IX_T2_PER = 5'h15;
  localparam logic [4:0] IX_PA_LAT = 5'h16;
  localparam logic [4:0] IX_PA_DIR = 5'h17;
  localparam logic [4:0] IX_PA_PIN = 5'h18;
  localparam logic [AXI_AW-1:0] ADDR_END = 8'h64;

  // per-register implemented bits, class values, kept bits, writable bits
  localparam logic [7:0] MASK [NREG] = '{8'hDF, 8'hDF, 8'h1F, 8'hFF,
    8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hBF, 8'h01, 8'hFF, 8'h7F,
    8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] POR_VAL [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hC0, 8'h00, 8'hFF, 8'h40, 8'h05, 8'h00, 8'hFF, 8'h00,
    8'h00, 8'hFF, 8'h00};
  localparam logic [7:0] POR_KEEP [NREG] = '{8'h3F, 8'hC0, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h00, 8'hFF};
  localparam logic [7:0] RST_VAL [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hC0, 8'h00, 8'hFF, 8'h40, 8'h05, 8'h00, 8'h00, 8'h7F,
    8'h00, 8'hFF, 8'h00};
  localparam logic [7:0] RST_KEEP [NREG] = '{8'h3F, 8'hC0, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h00, 8'hFF};
  localparam logic [7:0] WR_MASK [NREG] = '{8'hD3, 8'hDF, 8'h1F, 8'hFF,
    8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hF5, 8'hBF, 8'h01, 8'hFF, 8'h7F,
    8'hFF, 8'hFF, 8'h00};

  // status bit positions
  localparam int RC_SWBE = 6;
  localparam int RC_RIF = 4;
  localparam int RC_TOF = 3;
  localparam int RC_PDF = 2;
  localparam int RC_PONF = 1;
  localparam int RC_BOF = 0;
  localparam int SK_FUL = 7;
  localparam int SK_UNF = 6;
  localparam int IC_GEH = 7;
  localparam int IC_GEL = 6;
  localparam logic [7:0] RSTAT_PWRON = 8'h5C;
  localparam logic [7:0] T2_PER_WAKE = 8'h7F;
  localparam logic [7:0] IC_WAKE_FLAGS = 8'h07;
  localparam logic [7:0] PA_OSC_BITS = 8'hC0;

  localparam logic [PC_W-1:0] VEC_RESET = 21'h00000;
  localparam logic [PC_W-1:0] VEC_IRQ_HI = 21'h00008;
  localparam logic [PC_W-1:0] VEC_IRQ_LO = 21'h00018;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00002;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_RUN = 2'b01,
    MODE_IDLE = 2'b10,
    MODE_SLEEP = 2'b11
  } rci_mode_e;

  typedef enum logic [1:0] {
    BORCFG_OFF = 2'b00,
    BORCFG_SW = 2'b01,
    BORCFG_NOSLEEP = 2'b10,
    BORCFG_HW = 2'b11
  } rci_borcfg_e;

  typedef enum logic [1:0] {
    CLS_NONE = 2'b00,
    CLS_POR = 2'b01,
    CLS_RST = 2'b10,
    CLS_WAKE = 2'b11
  } rci_class_e;

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [PC_W-1:0] pc_target;
    logic pc_load;
    logic core_reset;
    logic bo_on;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rci_state_s;
endpackage

// *** src/rci_reset_cause.sv ***
// reset-cause recorder and per-class register initialisation
`timescale 1ns/1ps
`default_nettype none
module rci_reset_cause (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_on_evt,
  input wire logic brownout_evt,
  input wire logic master_clear_pin_n,
  input wire logic reset_instr_evt,
  input wire logic wdog_timeout_evt,
  input wire logic stack_overflow_evt,
  input wire logic stack_underflow_evt,
  input wire logic irq_wake_evt,
  input wire logic irq_wake_low,
  input wire logic [7:0] irq_wake_flags,
  input wire logic [1:0] pm_mode,
  input wire logic [20:0] cur_pc,
  input wire logic [1:0] brownout_enable_config,
  input wire logic stack_overflow_reset_enable,
  input wire logic gpio_bank_a_pins_free,
  input wire logic [7:0] gpio_bank_a_pin,
  output logic core_reset,
  output logic pc_load,
  output logic [20:0] pc_target,
  output logic brownout_active,
  output logic [7:0] gpio_bank_a_lat,
  output logic [7:0] gpio_bank_a_dir
);

  rci_pkg::rci_state_s s_q;
  rci_pkg::rci_state_s s_d;
  logic [7:0] pa_mask;
  logic sw_bo_mode;

  // port A high bits vanish unless the oscillator frees them
  assign pa_mask = gpio_bank_a_pins_free ? 8'hFF : ~rci_pkg::PA_OSC_BITS;
  assign sw_bo_mode = (brownout_enable_config == rci_pkg::BORCFG_SW);

  // bus handshakes
  assign s_axi_awready = ~s_q.aw_full & ~s_q.bvalid;
  assign s_axi_wready = ~s_q.w_full & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // block outputs
  assign core_reset = s_q.core_reset;
  assign pc_load = s_q.pc_load;
  assign pc_target = s_q.pc_target;
  assign brownout_active = s_q.bo_on;
  assign gpio_bank_a_lat = s_q.regs[rci_pkg::IX_PA_LAT] & pa_mask;
  assign gpio_bank_a_dir = s_q.regs[rci_pkg::IX_PA_DIR] & pa_mask;

  // next-state logic
  always_comb
  begin
    logic [4:0] rix;
    logic [4:0] wix;
    logic [7:0] rd;
    logic [7:0] wm;
    logic idle_sleep;
    logic pin_evt;
    logic sbor_keep;
    logic gie_any;
    logic [1:0] cls;
    rix = s_axi_araddr[6:2];
    wix = s_q.aw_addr[6:2];
    rd = 8'h00;
    wm = 8'h00;
    idle_sleep = (pm_mode == rci_pkg::MODE_IDLE) ||
                 (pm_mode == rci_pkg::MODE_SLEEP);
    pin_evt = s_q.pin_prev & ~s_q.pin_s2;
    sbor_keep = sw_bo_mode & s_q.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_SWBE];
    gie_any = s_q.regs[rci_pkg::IX_IRQCTL][rci_pkg::IC_GEH] |
              s_q.regs[rci_pkg::IX_IRQCTL][rci_pkg::IC_GEL];
    cls = rci_pkg::CLS_NONE;
    s_d = s_q;
    s_d.pc_load = 1'b0;
    s_d.core_reset = 1'b0;

    // two-stage synchronisers for the pins
    s_d.pin_s1 = master_clear_pin_n;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    s_d.pa_s1 = gpio_bank_a_pin;
    s_d.pa_s2 = s_q.pa_s1;

    // brown-out detector enable per configuration
    s_d.bo_on = (brownout_enable_config != rci_pkg::BORCFG_OFF) &&
      (!sw_bo_mode || s_q.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_SWBE]) &&
      !((brownout_enable_config == rci_pkg::BORCFG_NOSLEEP) &&
        (pm_mode == rci_pkg::MODE_SLEEP));

    // read channel
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = rci_pkg::RESP_OKAY;
      if (s_axi_araddr >= rci_pkg::ADDR_END)
      begin
        s_d.rresp = rci_pkg::RESP_SLVERR;
      end
      else if (rix == rci_pkg::IX_PA_PIN)
      begin
        rd = s_q.pa_s2 & pa_mask;
      end
      else
      begin
        rd = s_q.regs[rix] & rci_pkg::MASK[rix];
        if (rix == rci_pkg::IX_PA_LAT || rix == rci_pkg::IX_PA_DIR)
        begin
          rd = rd & pa_mask;
        end
        if (rix == rci_pkg::IX_RSTAT && !sw_bo_mode)
        begin
          rd[rci_pkg::RC_SWBE] = 1'b0;
        end
      end
      s_d.rdata = {24'h000000, rd};
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end

    // write address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_full && !s_q.bvalid)
    begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_full && !s_q.bvalid)
    begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_strb = s_axi_wstrb[0];
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rci_pkg::RESP_OKAY;
      if (s_q.aw_addr >= rci_pkg::ADDR_END)
      begin
        s_d.bresp = rci_pkg::RESP_SLVERR;
      end
      else if (s_q.w_strb)
      begin
        if (wix == rci_pkg::IX_PA_PIN)
        begin
          wix = rci_pkg::IX_PA_LAT; // port writes land in the latch
        end
        wm = rci_pkg::WR_MASK[wix];
        if (wix == rci_pkg::IX_PA_LAT || wix == rci_pkg::IX_PA_DIR)
        begin
          wm = wm & pa_mask;
        end
        if (wix == rci_pkg::IX_RSTAT && !sw_bo_mode)
        begin
          wm[rci_pkg::RC_SWBE] = 1'b0;
        end
        // software may set the power-on flag back to one
        s_d.regs[wix] = (s_q.regs[wix] & ~wm) | (s_q.w_data & wm);
      end
    end
    else if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // event decode, highest-ranking source wins
    if (power_on_evt)
    begin
      cls = rci_pkg::CLS_POR;
    end
    else if (brownout_evt && s_q.bo_on)
    begin
      cls = rci_pkg::CLS_POR;
    end
    else if (pin_evt || (wdog_timeout_evt && !idle_sleep) ||
             reset_instr_evt ||
             (stack_overflow_evt && stack_overflow_reset_enable) ||
             (stack_underflow_evt && stack_overflow_reset_enable))
    begin
      cls = rci_pkg::CLS_RST;
    end
    else if ((wdog_timeout_evt && idle_sleep) ||
             (irq_wake_evt && pm_mode != rci_pkg::MODE_FULL))
    begin
      cls = rci_pkg::CLS_WAKE;
    end

    // class initialisation; kept bits have no defined reset state
    for (int i = 0; i < rci_pkg::NREG; i++)
    begin
      if (cls == rci_pkg::CLS_POR)
      begin
        s_d.regs[i] = (s_d.regs[i] & rci_pkg::POR_KEEP[i]) |
                      (rci_pkg::POR_VAL[i] & ~rci_pkg::POR_KEEP[i]);
      end
      else if (cls == rci_pkg::CLS_RST)
      begin
        s_d.regs[i] = (s_d.regs[i] & rci_pkg::RST_KEEP[i]) |
                      (rci_pkg::RST_VAL[i] & ~rci_pkg::RST_KEEP[i]);
      end
    end

    // true resets restart at the reset vector
    if (cls == rci_pkg::CLS_POR || cls == rci_pkg::CLS_RST)
    begin
      s_d.core_reset = 1'b1;
      s_d.pc_load = 1'b1;
      s_d.pc_target = rci_pkg::VEC_RESET;
    end
    if (cls != rci_pkg::CLS_NONE)
    begin
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_SWBE] =
        power_on_evt | sbor_keep;
    end

    // status flag updates per source
    if (power_on_evt)
    begin
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_RIF] = 1'b1;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_TOF] = 1'b1;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_PDF] = 1'b1;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_PONF] = 1'b0;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_BOF] = 1'b0;
      s_d.regs[rci_pkg::IX_RSP][rci_pkg::SK_FUL] = 1'b0;
      s_d.regs[rci_pkg::IX_RSP][rci_pkg::SK_UNF] = 1'b0;
    end
    else if (brownout_evt && s_q.bo_on)
    begin
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_RIF] = 1'b1;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_TOF] = 1'b1;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_PDF] = 1'b1;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_BOF] = 1'b0;
    end
    else if (pin_evt)
    begin
      // full power leaves every flag alone
      if (pm_mode == rci_pkg::MODE_RUN)
      begin
        s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_TOF] = 1'b1;
      end
      else if (idle_sleep)
      begin
        s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_TOF] = 1'b1;
        s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_PDF] = 1'b0;
      end
    end
    else if (wdog_timeout_evt && !idle_sleep)
    begin
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_TOF] = 1'b0;
    end
    else if (reset_instr_evt)
    begin
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_RIF] = 1'b0;
    end
    else if (stack_overflow_evt && stack_overflow_reset_enable)
    begin
      s_d.regs[rci_pkg::IX_RSP][rci_pkg::SK_FUL] = 1'b1;
    end
    else if (stack_underflow_evt && stack_overflow_reset_enable)
    begin
      s_d.regs[rci_pkg::IX_RSP][rci_pkg::SK_UNF] = 1'b1;
    end
    else if (stack_underflow_evt)
    begin
      // error only: PC shows the reset vector, core keeps running
      s_d.regs[rci_pkg::IX_RSP][rci_pkg::SK_UNF] = 1'b1;
      s_d.pc_load = 1'b1;
      s_d.pc_target = rci_pkg::VEC_RESET;
    end
    else if (stack_overflow_evt)
    begin
      s_d.regs[rci_pkg::IX_RSP][rci_pkg::SK_FUL] = 1'b1;
    end
    else if (wdog_timeout_evt && idle_sleep)
    begin
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_TOF] = 1'b0;
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_PDF] = 1'b0;
      s_d.pc_load = 1'b1;
      s_d.pc_target = cur_pc + rci_pkg::PC_STEP;
    end
    else if (cls == rci_pkg::CLS_WAKE)
    begin
      s_d.regs[rci_pkg::IX_RSTAT][rci_pkg::RC_PDF] = 1'b0;
      s_d.regs[rci_pkg::IX_IRQCTL] = s_d.regs[rci_pkg::IX_IRQCTL] |
        (irq_wake_flags & rci_pkg::IC_WAKE_FLAGS);
      s_d.pc_load = 1'b1;
      s_d.pc_target = cur_pc + rci_pkg::PC_STEP;
      if (gie_any)
      begin
        s_d.pc_target = irq_wake_low ? rci_pkg::VEC_IRQ_LO :
                        rci_pkg::VEC_IRQ_HI;
        s_d.regs[rci_pkg::IX_TOP_U] = {3'h0, cur_pc[20:16]};
        s_d.regs[rci_pkg::IX_TOP_H] = cur_pc[15:8];
        s_d.regs[rci_pkg::IX_TOP_L] = cur_pc[7:0];
        s_d.regs[rci_pkg::IX_RSP][rci_pkg::PTR_W-1:0] =
          s_q.regs[rci_pkg::IX_RSP][rci_pkg::PTR_W-1:0] + 5'h01;
      end
    end

    // wake class value for the period register, low PC byte mirror
    if (cls == rci_pkg::CLS_WAKE)
    begin
      s_d.regs[rci_pkg::IX_T2_PER] = rci_pkg::T2_PER_WAKE;
    end
    if (s_d.pc_load)
    begin
      s_d.regs[rci_pkg::IX_PC_LO] = s_d.pc_target[7:0];
    end

    // synchronous reset loads the power-on register values, without a core_reset or pc_load pulse
    if (srst)
    begin
      s_d = '0;
      for (int i = 0; i < rci_pkg::NREG; i++)
      begin
        s_d.regs[i] = rci_pkg::POR_VAL[i];
      end
      s_d.regs[rci_pkg::IX_RSTAT] = rci_pkg::RSTAT_PWRON;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    s_q <= s_d;
  end

endmodule
`default_nettype wire
